// File: rtl/sequential_arithmetic_unit.sv
// Function
// - Registers are 40 bits: sign plus 39 magnitude
// - Negatives held as complement with respect to two
// - Complement inverts bits then adds one
// - Transfers clear destination, then gate ones in; the sum is written into the partner without a clear
// - Straight path copies accumulator into its partner
// - Left diagonal path partner into accumulator
// - Right diagonal path; n shifts repeat steps
// - Four one-way paths join the pair; sum returns straight
// - Adder takes accumulator and operand or complement
// - Sum goes to partner, then back to accumulator
// - Subtract adds complement, sign carry dropped
// - Multiply: multiplier MQ, multiplicand operand, acc clear
// - Test MQ low bit; add multiplicand when one
// - Each multiply step shifts acc and MQ right
// - Acc low bit enters MQ top bit
// - Divide: dividend in acc, divisor in operand
// - Signs differ add divisor, agree add complement
// - Quotient bit into MQ low position
// - Shift acc and MQ left; repeat 39 times
// - Operand register never shifts in arithmetic
// - Second partner serves MQ like first serves acc
// - Auxiliary register serves control unit only
`timescale 1ns/10ps
module sequential_arithmetic_unit
	import sau_pkg::*;
#(
	parameter int STEPS = MAG_BITS
) (
	input  wire logic     clk,
	input  wire logic     rstn,
	input  wire sau_req_t request,
	output sau_rsp_t      response
);
	if (STEPS < 1 || STEPS > int'(STEP_LAST)) begin : g_steps_check
		$error("sequential_arithmetic_unit STEPS out of range");
	end

	localparam logic [STEP_W-1:0] STEP_COUNT = STEP_W'(STEPS);

	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_CLRP    = 9'h002,
		ST_GATEP   = 9'h004,
		ST_CLRA    = 9'h008,
		ST_GATEA   = 9'h010,
		ST_SUMP    = 9'h020,
		ST_SUMCLR  = 9'h040,
		ST_SUMBACK = 9'h080,
		ST_DONE    = 9'h100
	} sau_state_t;

	typedef enum logic [2:0] {
		SEQ_SHIFT = 3'h1,
		SEQ_MUL   = 3'h2,
		SEQ_DIV   = 3'h4
	} sau_seq_t;

	typedef struct packed {
		sau_state_t        state;
		sau_seq_t          seq;
		logic              shiftLeft;
		logic              doAdd;
		logic              subtract;
		logic              quotientBit;
		logic              singleAdd;
		logic [STEP_W-1:0] stepsLeft;
		logic [WORD_W-1:0] accShiftPartner;
		logic [WORD_W-1:0] accumulator;
		logic [WORD_W-1:0] mqShiftPartner;
		logic [WORD_W-1:0] multiplierQuotient;
		logic [WORD_W-1:0] operand;
		logic [WORD_W-1:0] controlAux;
		sau_rsp_t          rsp;
	} sau_core_t;

	sau_core_t         core_reg;
	sau_core_t         core_next;
	logic [WORD_W-1:0] adderSum;

	// Left diagonal gate: bit i of destination from bit i-1 of source
	function automatic logic [WORD_W-1:0] gateLeft(
		input logic [WORD_W-1:0] src,
		input logic              fill
	);
		gateLeft = {src[WORD_W-2:0], fill};
	endfunction : gateLeft

	// Right diagonal gate: bit i of destination from bit i+1 of source
	function automatic logic [WORD_W-1:0] gateRight(
		input logic [WORD_W-1:0] src,
		input logic              fill
	);
		gateRight = {fill, src[WORD_W-1:1]};
	endfunction : gateRight

	sau_adder #(
		.WIDTH       (WORD_W)
	) adder (
		.addendA     (core_reg.accumulator),
		.addendB     (core_reg.operand),
		.complementB (core_reg.subtract),
		.sum         (adderSum)
	);

	always_comb begin
		core_next = core_reg;
		core_next.rsp.done = 1'b0;
		unique case (core_reg.state)
			ST_IDLE: begin
				if (request.valid) begin
					unique case (request.cmd)
						CMD_LDACC: begin
							core_next.accumulator = request.data;
						end
						CMD_LDMQ: begin
							core_next.multiplierQuotient = request.data;
						end
						CMD_LDOPR: begin
							core_next.operand = request.data;
						end
						CMD_LDAUX: begin
							core_next.controlAux = request.data;
						end
						CMD_CLRACC: begin
							core_next.accumulator = WORD_ZERO;
						end
						CMD_ADD, CMD_SUB: begin
							core_next.seq = SEQ_SHIFT;
							core_next.singleAdd = 1'b1;
							core_next.subtract = (request.cmd == CMD_SUB);
							core_next.state = ST_SUMP;
						end
						CMD_SHL, CMD_SHR: begin
							if (request.count != STEP_ZERO) begin
								core_next.seq = SEQ_SHIFT;
								core_next.singleAdd = 1'b0;
								core_next.doAdd = 1'b0;
								core_next.shiftLeft = (request.cmd == CMD_SHL);
								core_next.stepsLeft = request.count;
								core_next.state = ST_CLRP;
							end
						end
						CMD_MUL: begin
							core_next.seq = SEQ_MUL;
							core_next.accumulator = WORD_ZERO;
							core_next.singleAdd = 1'b0;
							core_next.shiftLeft = 1'b0;
							core_next.subtract = 1'b0;
							core_next.stepsLeft = STEP_COUNT;
							core_next.doAdd =
								core_reg.multiplierQuotient[LSB_POS];
							core_next.state = core_next.doAdd ? ST_SUMP : ST_CLRP;
						end
						CMD_DIV: begin
							core_next.seq = SEQ_DIV;
							core_next.singleAdd = 1'b0;
							core_next.shiftLeft = 1'b1;
							core_next.stepsLeft = STEP_COUNT;
							core_next.doAdd = 1'b1;
							core_next.subtract = (core_reg.accumulator[SIGN_POS]
								== core_reg.operand[SIGN_POS]);
							core_next.quotientBit = ~core_next.subtract;
							core_next.state = ST_SUMP;
						end
						default: begin
						end
					endcase
				end
			end
			ST_SUMP: begin
				core_next.accShiftPartner = adderSum;
				core_next.state = ST_SUMCLR;
			end
			ST_SUMCLR: begin
				core_next.accumulator = WORD_ZERO;
				core_next.state = ST_SUMBACK;
			end
			ST_SUMBACK: begin
				core_next.accumulator =
					core_reg.accumulator | core_reg.accShiftPartner;
				if (core_reg.singleAdd) begin
					core_next.state = ST_DONE;
				end else begin
					if (core_reg.seq == SEQ_DIV) begin
						core_next.multiplierQuotient[LSB_POS] =
							core_reg.quotientBit;
					end
					core_next.state = ST_CLRP;
				end
			end
			ST_CLRP: begin
				core_next.accShiftPartner = WORD_ZERO;
				core_next.mqShiftPartner = WORD_ZERO;
				core_next.state = ST_GATEP;
			end
			ST_GATEP: begin
				core_next.accShiftPartner =
					core_reg.accShiftPartner | core_reg.accumulator;
				core_next.mqShiftPartner =
					core_reg.mqShiftPartner | core_reg.multiplierQuotient;
				core_next.state = ST_CLRA;
			end
			ST_CLRA: begin
				core_next.accumulator = WORD_ZERO;
				if (core_reg.seq != SEQ_SHIFT) begin
					core_next.multiplierQuotient = WORD_ZERO;
				end
				core_next.state = ST_GATEA;
			end
			ST_GATEA: begin
				core_next.stepsLeft = core_reg.stepsLeft - STEP_ONE;
				unique case (core_reg.seq)
					SEQ_SHIFT: begin
						if (core_reg.shiftLeft) begin
							core_next.accumulator = gateLeft(
								core_reg.accShiftPartner, 1'b0);
						end else begin
							core_next.accumulator = gateRight(
								core_reg.accShiftPartner, 1'b0);
						end
					end
					SEQ_MUL: begin
						core_next.accumulator = gateRight(
							core_reg.accShiftPartner,
							core_reg.accShiftPartner[SIGN_POS]);
						core_next.multiplierQuotient = gateRight(
							core_reg.mqShiftPartner,
							core_reg.accShiftPartner[LSB_POS]);
					end
					SEQ_DIV: begin
						core_next.accumulator = gateLeft(
							core_reg.accShiftPartner,
							core_reg.mqShiftPartner[SIGN_POS]);
						core_next.multiplierQuotient = gateLeft(
							core_reg.mqShiftPartner, 1'b0);
					end
					default: begin
					end
				endcase
				if (core_reg.stepsLeft == STEP_ONE) begin
					core_next.state = ST_DONE;
				end else if (core_reg.seq == SEQ_MUL) begin
					core_next.doAdd = core_reg.mqShiftPartner[LSB_POS + 1];
					core_next.state =
						core_next.doAdd ? ST_SUMP : ST_CLRP;
				end else if (core_reg.seq == SEQ_DIV) begin
					core_next.subtract = (core_next.accumulator[SIGN_POS]
						== core_reg.operand[SIGN_POS]);
					core_next.quotientBit = ~core_next.subtract;
					core_next.state = ST_SUMP;
				end else begin
					core_next.state = ST_CLRP;
				end
			end
			ST_DONE: begin
				core_next.rsp.done = 1'b1;
				core_next.state = ST_IDLE;
			end
			default: begin
				core_next.state = ST_IDLE;
			end
		endcase
		core_next.rsp.busy = (core_next.state != ST_IDLE);
		core_next.rsp.accumulator = core_next.accumulator;
		core_next.rsp.multiplierQuotient = core_next.multiplierQuotient;
		core_next.rsp.operand = core_next.operand;
		core_next.rsp.controlAux = core_next.controlAux;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_reg.state <= ST_IDLE;
			core_reg.seq <= SEQ_SHIFT;
			core_reg.shiftLeft <= 1'b0;
			core_reg.doAdd <= 1'b0;
			core_reg.subtract <= 1'b0;
			core_reg.quotientBit <= 1'b0;
			core_reg.singleAdd <= 1'b0;
			core_reg.stepsLeft <= STEP_ZERO;
			core_reg.accShiftPartner <= WORD_ZERO;
			core_reg.accumulator <= WORD_ZERO;
			core_reg.mqShiftPartner <= WORD_ZERO;
			core_reg.multiplierQuotient <= WORD_ZERO;
			core_reg.operand <= WORD_ZERO;
			core_reg.controlAux <= WORD_ZERO;
			core_reg.rsp <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	assign response = core_reg.rsp;

	// Four gate paths exist between accumulator and its partner; only one runs toward the partner
endmodule : sequential_arithmetic_unit

// File: rtl/sau_pkg.sv
package sau_pkg;
	localparam int WORD_W     = 40;
	localparam int MAG_BITS   = 39;
	localparam int STEP_W     = 6;
	localparam logic [WORD_W-1:0] WORD_ZERO = 40'h00_0000_0000;
	localparam logic [WORD_W-1:0] WORD_ONE  = 40'h00_0000_0001;
	localparam int SIGN_POS   = WORD_W - 1;
	localparam int LSB_POS    = 0;
	localparam logic [STEP_W-1:0] STEP_ZERO = 6'h00;
	localparam logic [STEP_W-1:0] STEP_ONE  = 6'h01;
	localparam logic [STEP_W-1:0] STEP_LAST = 6'h27;

	typedef enum logic [3:0] {
		CMD_NONE  = 4'h0,
		CMD_LDACC = 4'h1,
		CMD_LDMQ  = 4'h2,
		CMD_LDOPR = 4'h3,
		CMD_LDAUX = 4'h4,
		CMD_ADD   = 4'h5,
		CMD_SUB   = 4'h6,
		CMD_SHL   = 4'h7,
		CMD_SHR   = 4'h8,
		CMD_MUL   = 4'h9,
		CMD_DIV   = 4'hA,
		CMD_CLRACC = 4'hB
	} sau_cmd_t;

	typedef struct packed {
		logic              valid;
		sau_cmd_t          cmd;
		logic [WORD_W-1:0] data;
		logic [STEP_W-1:0] count;
	} sau_req_t;

	typedef struct packed {
		logic              done;
		logic              busy;
		logic [WORD_W-1:0] accumulator;
		logic [WORD_W-1:0] multiplierQuotient;
		logic [WORD_W-1:0] operand;
		logic [WORD_W-1:0] controlAux;
	} sau_rsp_t;
endpackage : sau_pkg

// File: rtl/sau_adder.sv
`timescale 1ns/10ps
module sau_adder
	import sau_pkg::*;
#(
	parameter int WIDTH = WORD_W
) (
	input  wire logic [WIDTH-1:0] addendA,
	input  wire logic [WIDTH-1:0] addendB,
	input  wire logic             complementB,
	output logic      [WIDTH-1:0] sum
);
	if (WIDTH < 2) begin : g_width_check
		$error("sau_adder width too small");
	end

	logic [WIDTH-1:0] operandB;

	always_comb begin
		operandB = addendB;
		if (complementB) begin
			operandB = (~addendB) + WIDTH'(1);
		end
		sum = addendA + operandB;
	end
endmodule : sau_adder

// File: bench/sau_props.sv
`timescale 1ns/10ps
module sau_props
	import sau_pkg::*;
#(
	parameter int STEPS = MAG_BITS
) (
	input wire logic     clk,
	input wire logic     rstn,
	input wire sau_req_t request,
	input wire sau_rsp_t response
);
	localparam int MUL_MIN = 4 * STEPS;
	localparam int MUL_MAX = 7 * STEPS + 2;
	logic take;
	assign take = request.valid && !response.busy;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_done_pulse: assert property (
		response.done |=> !response.done)
		else $error("done held over one cycle");
	a_busy_fall: assert property (
		$fell(response.busy) |-> response.done)
		else $error("busy dropped without done");
	a_add_len: assert property (
		take && request.cmd inside {CMD_ADD, CMD_SUB} |-> ##[4:5] response.done)
		else $error("add or subtract length wrong");
	a_shl_len: assert property (
		take && request.cmd == CMD_SHL && request.count == 6'h01
		|-> ##[4:6] response.done)
		else $error("one place shift length wrong");
	a_mul_len: assert property (
		take && request.cmd == CMD_MUL |-> ##[MUL_MIN:MUL_MAX] response.done)
		else $error("multiply length wrong");
	a_opr_stable: assert property (
		response.busy |=> $stable(response.operand))
		else $error("operand moved during a sequence");
	a_aux_stable: assert property (
		response.busy |=> $stable(response.controlAux))
		else $error("auxiliary moved during a sequence");
	a_load_opr: assert property (
		take && request.cmd == CMD_LDOPR
		|-> ##2 (response.operand == $past(request.data, 2)))
		else $error("operand load wrong");
endmodule : sau_props

bind sequential_arithmetic_unit sau_props #(.STEPS(STEPS)) u_sau_props (
	.clk      (clk),
	.rstn     (rstn),
	.request  (request),
	.response (response)
);

// File: bench/sau_ctrl_model.sv
`timescale 1ns/10ps
module sau_ctrl_model
	import sau_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rstn,
	output sau_req_t      request,
	input  wire sau_rsp_t response
);
	initial request = '0;

	// Strobe one cycle, release data inverted, optionally await done
	task automatic issue(input sau_cmd_t c, input logic [WORD_W-1:0] d,
		input logic [STEP_W-1:0] n, input bit w);
		int k;
		k = 0;
		@(negedge clk);
		request <= '{1'b1, c, d, n};
		@(negedge clk);
		request <= '{1'b0, CMD_NONE, ~d, ~n};
		while (w && response.done !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
	endtask : issue
endmodule : sau_ctrl_model

// File: bench/sequential_arithmetic_unit_tb.sv
`timescale 1ns/10ps
module sequential_arithmetic_unit_tb
	import sau_pkg::*;
;
	localparam int STEPS = 4;
	typedef struct packed {
		sau_cmd_t          cmd;
		logic [WORD_W-1:0] a;
		logic [WORD_W-1:0] b;
		logic [STEP_W-1:0] cnt;
		logic [WORD_W-1:0] exp;
	} sau_row_t;

	logic     clk;
	logic     rstn;
	sau_req_t request;
	sau_rsp_t response;
	int       errCount;
	int       compares;
	logic [2*WORD_W-1:0] refWord;
	sau_row_t rows [8] = '{
		'{CMD_ADD, 40'h0000000003, 40'h0000000005, 6'h00, 40'h0000000008},
		'{CMD_SUB, 40'h0000000003, 40'h0000000005, 6'h00, 40'hFFFFFFFFFE},
		'{CMD_SUB, 40'h0000000005, 40'h0000000003, 6'h00, 40'h0000000002},
		'{CMD_ADD, 40'h7FFFFFFFFF, 40'h0000000001, 6'h00, 40'h8000000000},
		'{CMD_SHL, 40'h0000000001, 40'h0000000000, 6'h03, 40'h0000000008},
		'{CMD_SHR, 40'h8000000000, 40'h0000000000, 6'h01, 40'h4000000000},
		'{CMD_SHL, 40'h8000000001, 40'h0000000000, 6'h01, 40'h0000000002},
		'{CMD_SHR, 40'h0000000005, 40'h0000000000, 6'h02, 40'h0000000001}
	};

	sequential_arithmetic_unit #(.STEPS(STEPS)) u_sequential_arithmetic_unit (
		.clk      (clk),
		.rstn     (rstn),
		.request  (request),
		.response (response)
	);
	sau_ctrl_model u_sau_ctrl_model (
		.clk      (clk),
		.rstn     (rstn),
		.request  (request),
		.response (response)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	function automatic logic [2*WORD_W-1:0] mul_ref(logic [WORD_W-1:0] m, q);
		logic [WORD_W-1:0] a;
		a = WORD_ZERO;
		for (int i = 0; i < STEPS; i++) begin
			if (q[LSB_POS])
				a = a + m;
			{a, q} = {a[SIGN_POS], a, q[WORD_W-1:1]};
		end
		return {a, q};
	endfunction : mul_ref

	function automatic logic [2*WORD_W-1:0] div_ref(logic [WORD_W-1:0] a, d, q);
		logic s;
		for (int i = 0; i < STEPS; i++) begin
			s = a[SIGN_POS] != d[SIGN_POS];
			a = s ? a + d : a + ~d + WORD_ONE;
			q[LSB_POS] = s;
			{a, q} = {a[WORD_W-2:0], q, 1'b0};
		end
		return {a, q};
	endfunction : div_ref

	task automatic check(input logic [WORD_W-1:0] got, exp);
		compares++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic go(sau_cmd_t c, logic [WORD_W-1:0] d,
		logic [STEP_W-1:0] n, bit w);
		u_sau_ctrl_model.issue(c, d, n, w);
		if (w) begin
			check({39'h0, response.done}, WORD_ONE);
		end
	endtask : go

	task automatic close_out;
		$display("errors %0d compares %0d", errCount, compares);
		if (errCount == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	initial begin
		#(100ns * 20000);
		errCount++;
		close_out();
	end

	initial begin
		errCount = 0;
		compares = 0;
		rstn = 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		check(response.accumulator | response.multiplierQuotient |
			response.operand | response.controlAux, WORD_ZERO);
		check({38'h0, response.done, response.busy}, WORD_ZERO);
		foreach (rows[i]) begin
			go(CMD_LDACC, rows[i].a, 6'h00, 1'b0);
			go(CMD_LDOPR, rows[i].b, 6'h00, 1'b0);
			go(rows[i].cmd, WORD_ZERO, rows[i].cnt, 1'b1);
			check(response.accumulator, rows[i].exp);
		end
		// Multiply with a negative multiplicand
		go(CMD_LDMQ, 40'h000000000B, 6'h00, 1'b0);
		go(CMD_LDOPR, 40'hFFFFFFFFFD, 6'h00, 1'b0);
		go(CMD_CLRACC, WORD_ZERO, 6'h00, 1'b0);
		go(CMD_LDAUX, 40'h5A5A5A5A5A, 6'h00, 1'b0);
		go(CMD_MUL, WORD_ZERO, 6'h00, 1'b1);
		refWord = mul_ref(40'hFFFFFFFFFD, 40'h000000000B);
		check(response.accumulator, refWord[2*WORD_W-1:WORD_W]);
		check(response.multiplierQuotient, refWord[WORD_W-1:0]);
		check(response.controlAux, 40'h5A5A5A5A5A);
		// Loads ignored while busy; unit clears acc itself
		go(CMD_MUL, WORD_ZERO, 6'h00, 1'b0);
		go(CMD_LDOPR, 40'h1111111111, 6'h00, 1'b0);
		go(CMD_NONE, WORD_ZERO, 6'h00, 1'b1);
		check(response.operand, 40'hFFFFFFFFFD);
		refWord = mul_ref(40'hFFFFFFFFFD, refWord[WORD_W-1:0]);
		check(response.accumulator, refWord[2*WORD_W-1:WORD_W]);
		check(response.multiplierQuotient, refWord[WORD_W-1:0]);
		// Non-restoring divide
		go(CMD_LDACC, 40'h2000000000, 6'h00, 1'b0);
		go(CMD_LDOPR, 40'h4000000000, 6'h00, 1'b0);
		go(CMD_LDMQ, WORD_ZERO, 6'h00, 1'b0);
		go(CMD_DIV, WORD_ZERO, 6'h00, 1'b1);
		refWord = div_ref(40'h2000000000, 40'h4000000000, WORD_ZERO);
		check(response.accumulator, refWord[2*WORD_W-1:WORD_W]);
		check(response.multiplierQuotient, refWord[WORD_W-1:0]);
		// Reset in the middle of a multiply
		go(CMD_MUL, WORD_ZERO, 6'h00, 1'b0);
		repeat (3) @(negedge clk);
		check({39'h0, response.busy}, WORD_ONE);
		rstn = 1'b0;
		@(negedge clk);
		check(response.accumulator | response.multiplierQuotient |
			response.operand | response.controlAux, WORD_ZERO);
		check({38'h0, response.done, response.busy}, WORD_ZERO);
		rstn = 1'b1;
		go(CMD_LDOPR, 40'h0000000007, 6'h00, 1'b0);
		go(CMD_ADD, WORD_ZERO, 6'h00, 1'b1);
		check(response.accumulator, 40'h0000000007);
		close_out();
	end
endmodule : sequential_arithmetic_unit_tb
